// >>> core/status_pkg.sv
/*
 * constants, field positions and enumerations shared by the status and
 * condition logic of a 16-bit processor.
 * assumes bit 0 is the most significant bit of every status and instruction
 * word, so those words are declared [0:15].
 */
package status_pkg;

  localparam int WORD_W = 16;

  // level status word bit positions
  localparam int IND_EVEN   = 0;
  localparam int IND_CARRY  = 1;
  localparam int IND_OVF    = 2;
  localparam int IND_NEG    = 3;
  localparam int IND_ZERO   = 4;
  localparam int SUP_BIT    = 8;
  localparam int INPROC_BIT = 9;
  localparam int TRACE_BIT  = 10;
  localparam int SMASK_BIT  = 11;

  // bits that exist; the rest read as zero
  localparam logic [0:15] LSW_USED_MASK = 16'hF8F0;
  // supervisor state only, as after initial program load
  localparam logic [0:15] LSW_RESET     = 16'h0080;

  // instruction word fields
  localparam int OPC_MSB  = 0;
  localparam int OPC_LSB  = 4;
  localparam int REG_MSB  = 5;
  localparam int REG_LSB  = 7;
  localparam int IMM_MSB  = 8;
  localparam int IMM_LSB  = 15;
  localparam int FUNC_MSB = 11;
  localparam int FUNC_LSB = 15;

  localparam logic [4:0] OPC_ADD_BYTE_IMM = 5'h00;

  typedef enum logic [2:0] {
    add_word_op              = 3'h0,
    sub_word_op              = 3'h1,
    add_word_with_carry_op   = 3'h2,
    sub_word_with_carry_op   = 3'h3,
    add_carry_to_reg_op      = 3'h4,
    sub_carry_from_reg_op    = 3'h5,
    compare_op               = 3'h6,
    add_byte_immediate_op    = 3'h7
  } alu_op_type;

  typedef enum logic [3:0] {
    cond_zero                     = 4'h0,
    cond_not_zero                 = 4'h1,
    cond_positive                 = 4'h2,
    cond_not_positive             = 4'h3,
    cond_negative                 = 4'h4,
    cond_not_negative             = 4'h5,
    cond_even                     = 4'h6,
    cond_not_even                 = 4'h7,
    cond_less                     = 4'h8,
    cond_less_equal               = 4'h9,
    cond_greater_equal            = 4'hA,
    cond_greater                  = 4'hB,
    cond_logical_less_equal       = 4'hC,
    branch_logical_less           = 4'hD,
    cond_logical_greater          = 4'hE,
    branch_logical_greater_equal  = 4'hF
  } cond_type;

endpackage : status_pkg

// >>> core/alu_if.sv
/*
 * carrier between the status logic and its word adder.
 * assumes a purely combinational adder on the far side.
 */
interface alu_if;
  logic [15:0] a;
  logic [15:0] b;
  logic        cin;
  logic        sub;
  logic [15:0] result;
  logic        cout;
  logic        ovf;

  modport client (output a, b, cin, sub, input result, cout, ovf);
  modport adder  (input a, b, cin, sub, output result, cout, ovf);
endinterface : alu_if

// >>> core/word_adder.sv
/*
 * one-word adder and subtractor with carry or borrow in and out.
 * assumes the caller supplies the minuend on a; cin is a borrow when sub is high.
 */
module word_adder (
  alu_if.adder port
);

  logic [15:0] b_eff;
  logic        c_eff;
  logic [16:0] sum;

  // subtract is a + ~b + ~borrow; the carry out is inverted back into a borrow
  always_comb begin
    b_eff       = port.sub ? ~port.b : port.b;
    c_eff       = port.sub ? ~port.cin : port.cin;
    sum         = {1'b0, port.a} + {1'b0, b_eff} + {16'h0000, c_eff};
    port.result = sum[15:0];
    port.cout   = port.sub ? ~sum[16] : sum[16];
    port.ovf    = (port.a[15] == b_eff[15]) && (sum[15] != port.a[15]);
  end

endmodule : word_adder

// >>> core/status_condition_unit.sv
/*
 * level status word, result indicators with multi-word chaining, branch
 * condition evaluation, state bits and one-word instruction field decode.
 * assumes the execution unit presents one operation per enabled cycle and
 * routes taken branches itself; interrupt sources arrive as one-cycle pulses.
 */
// Behaviour
// - word-with-carry ops add or subtract two registers plus prior carry
// - carry-register ops apply only the prior carry to one register
// - chained zero set only when every result word was zero
// - chained even follows low bit of least significant word
// - chained negative follows high bit of most significant word
// - chained carry flags unsigned overflow of the whole result
// - chained overflow flags signed overflow of the whole result
// - indicators sit at bits 0 to 4: even, carry, overflow, negative, zero
// - branch evaluates condition; not-variants transfer when condition false
// - logically-less-than is true exactly when carry is set
// - logically-greater-or-equal is true exactly when carry is clear
// - bit 8 one is supervisor state; privileged ops need it
// - class interrupts, I/O interrupts and program load set supervisor
// - set-level-block writes the supervisor bit either way
// - bit 9 marks level in process; level exit clears it
// - set-level-block sets or clears the in-process bit
// - trace bit raises trace interrupt at each instruction start
// - summary mask zero blocks every priority interrupt
// - instructions are 16-bit words; bits 0 to 4 are the opcode
// - shared opcodes are told apart by the function field
// - add-byte-immediate is opcode 00000, register 5-7, immediate 8-15
// - compare sets indicators like subtract, leaving operands alone
module status_condition_unit (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_clk_en,
  input  wire logic                 i_instr_valid,
  input  wire logic [0:15]          i_instr,
  input  wire logic                 i_op_valid,
  input  wire status_pkg::alu_op_type i_op,
  input  wire logic [15:0]          i_opnd_a,
  input  wire logic [15:0]          i_opnd_b,
  input  wire logic                 i_privileged,
  input  wire logic                 i_branch_valid,
  input  wire logic                 i_branch_not,
  input  wire status_pkg::cond_type i_cond,
  input  wire logic                 i_class_irq,
  input  wire logic                 i_io_irq,
  input  wire logic                 i_initial_program_load,
  input  wire logic                 i_level_enter,
  input  wire logic                 i_level_exit_op,
  input  wire logic                 i_set_level_block_op,
  input  wire logic [0:15]          i_set_level_block_op_word,
  input  wire logic                 i_instr_start,
  input  wire logic                 i_prio_irq_req,
  output logic [0:15]               o_level_status_word,
  output logic [15:0]               o_result,
  output logic                      o_result_we,
  output logic                      o_branch_done,
  output logic                      o_branch_taken,
  output logic                      o_program_check,
  output logic                      o_trace_irq,
  output logic                      o_prio_irq_grant,
  output logic                      o_dec_valid,
  output logic [4:0]                o_dec_opcode,
  output logic [4:0]                o_dec_func,
  output logic [2:0]                o_dec_reg,
  output logic [7:0]                o_dec_imm,
  output logic                      o_dec_add_byte_imm
);

  alu_if alu ();

  word_adder u_adder (
    .port (alu.adder)
  );

  logic [0:15] lsw_r;
  logic [0:15] lsw_nxt;
  logic        chained;
  logic        priv_fault;
  logic        op_take;
  logic        trace_fire;
  logic        cond_hit;
  logic        ind_e;
  logic        ind_c;
  logic        ind_o;
  logic        ind_n;
  logic        ind_z;

  logic [15:0] result_r;
  logic [15:0] result_nxt;
  logic        result_we_r;
  logic        result_we_nxt;
  logic        branch_done_r;
  logic        branch_done_nxt;
  logic        branch_taken_r;
  logic        branch_taken_nxt;
  logic        prog_check_r;
  logic        prog_check_nxt;
  logic        trace_irq_r;
  logic        trace_irq_nxt;
  logic        dec_valid_r;
  logic        dec_valid_nxt;
  logic [0:15] dec_word_r;
  logic [0:15] dec_word_nxt;

  assign ind_e = lsw_r[status_pkg::IND_EVEN];
  assign ind_c = lsw_r[status_pkg::IND_CARRY];
  assign ind_o = lsw_r[status_pkg::IND_OVF];
  assign ind_n = lsw_r[status_pkg::IND_NEG];
  assign ind_z = lsw_r[status_pkg::IND_ZERO];

  // privileged requests are refused outright in problem state
  assign priv_fault = (i_set_level_block_op | i_level_exit_op | i_privileged)
                      & ~lsw_r[status_pkg::SUP_BIT];
  assign op_take    = i_op_valid & ~(i_set_level_block_op & ~priv_fault);
  assign trace_fire = i_instr_start & lsw_r[status_pkg::TRACE_BIT];

  // combinational grant: a masked request never leaves this block
  assign o_prio_irq_grant = i_prio_irq_req & lsw_r[status_pkg::SMASK_BIT];

  always_comb begin : operand_select
    alu.a   = i_opnd_a;
    alu.b   = i_opnd_b;
    alu.cin = 1'b0;
    alu.sub = 1'b0;
    chained = 1'b0;
    case (i_op)
      status_pkg::add_word_op: begin
        alu.sub = 1'b0;
      end
      status_pkg::sub_word_op,
      status_pkg::compare_op: begin
        alu.sub = 1'b1;
      end
      status_pkg::add_word_with_carry_op: begin
        alu.cin = ind_c;
        chained = 1'b1;
      end
      status_pkg::sub_word_with_carry_op: begin
        alu.sub = 1'b1;
        alu.cin = ind_c;
        chained = 1'b1;
      end
      status_pkg::add_carry_to_reg_op: begin
        alu.b   = 16'h0000;
        alu.cin = ind_c;
        chained = 1'b1;
      end
      status_pkg::sub_carry_from_reg_op: begin
        alu.sub = 1'b1;
        alu.b   = 16'h0000;
        alu.cin = ind_c;
        chained = 1'b1;
      end
      status_pkg::add_byte_immediate_op: begin
        alu.b = {{8{i_opnd_b[7]}}, i_opnd_b[7:0]};
      end
      default: begin
        alu.sub = 1'b0;
      end
    endcase
  end

  always_comb begin : cond_eval
    case (i_cond)
      status_pkg::cond_zero:                    cond_hit = ind_z;
      status_pkg::cond_not_zero:                cond_hit = ~ind_z;
      status_pkg::cond_positive:                cond_hit = ~ind_n & ~ind_z;
      status_pkg::cond_not_positive:            cond_hit = ind_n | ind_z;
      status_pkg::cond_negative:                cond_hit = ind_n;
      status_pkg::cond_not_negative:            cond_hit = ~ind_n;
      status_pkg::cond_even:                    cond_hit = ind_e;
      status_pkg::cond_not_even:                cond_hit = ~ind_e;
      status_pkg::cond_less:                    cond_hit = ind_n ^ ind_o;
      status_pkg::cond_less_equal:              cond_hit = (ind_n ^ ind_o) | ind_z;
      status_pkg::cond_greater_equal:           cond_hit = ~(ind_n ^ ind_o);
      status_pkg::cond_greater:                 cond_hit = ~(ind_n ^ ind_o) & ~ind_z;
      status_pkg::cond_logical_less_equal:      cond_hit = ind_c | ind_z;
      status_pkg::branch_logical_less:          cond_hit = ind_c;
      status_pkg::cond_logical_greater:         cond_hit = ~ind_c & ~ind_z;
      status_pkg::branch_logical_greater_equal: cond_hit = ~ind_c;
      default:                                  cond_hit = 1'b0;
    endcase
  end

  always_comb begin : status_next
    lsw_nxt = lsw_r;
    if (i_set_level_block_op && !priv_fault) begin
      // loads indicators, supervisor, in-process, trace and mask in one go
      lsw_nxt = i_set_level_block_op_word & status_pkg::LSW_USED_MASK;
    end else if (i_op_valid) begin
      lsw_nxt[status_pkg::IND_CARRY] = alu.cout;
      lsw_nxt[status_pkg::IND_OVF]   = alu.ovf;
      lsw_nxt[status_pkg::IND_NEG]   = alu.result[15];
      // a chain only keeps zero if every earlier word was zero too
      lsw_nxt[status_pkg::IND_ZERO]  = (alu.result == 16'h0000)
                                       & (~chained | ind_z);
      lsw_nxt[status_pkg::IND_EVEN]  = chained ? ind_e : ~alu.result[0];
    end
    if (i_level_enter) begin
      lsw_nxt[status_pkg::INPROC_BIT] = 1'b1;
    end else if (i_level_exit_op && !priv_fault) begin
      lsw_nxt[status_pkg::INPROC_BIT] = 1'b0;
    end
    // entry events win over a same-cycle block load clearing the bit
    if (i_class_irq || i_io_irq || i_initial_program_load || priv_fault || trace_fire) begin
      lsw_nxt[status_pkg::SUP_BIT] = 1'b1;
    end
  end

  always_comb begin : output_next
    result_nxt       = result_r;
    result_we_nxt    = 1'b0;
    branch_done_nxt  = 1'b0;
    branch_taken_nxt = 1'b0;
    prog_check_nxt   = priv_fault;
    trace_irq_nxt    = trace_fire;
    dec_valid_nxt    = i_instr_valid;
    dec_word_nxt     = dec_word_r;
    if (op_take) begin
      result_nxt    = alu.result;
      result_we_nxt = (i_op != status_pkg::compare_op);
    end
    if (i_branch_valid) begin
      branch_done_nxt  = 1'b1;
      branch_taken_nxt = cond_hit ^ i_branch_not;
    end
    if (i_instr_valid) begin
      dec_word_nxt = i_instr;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lsw_r          <= status_pkg::LSW_RESET;
      result_r       <= 16'h0000;
      result_we_r    <= 1'b0;
      branch_done_r  <= 1'b0;
      branch_taken_r <= 1'b0;
      prog_check_r   <= 1'b0;
      trace_irq_r    <= 1'b0;
      dec_valid_r    <= 1'b0;
      dec_word_r     <= 16'h0000;
    end else if (i_clk_en) begin
      lsw_r          <= lsw_nxt;
      result_r       <= result_nxt;
      result_we_r    <= result_we_nxt;
      branch_done_r  <= branch_done_nxt;
      branch_taken_r <= branch_taken_nxt;
      prog_check_r   <= prog_check_nxt;
      trace_irq_r    <= trace_irq_nxt;
      dec_valid_r    <= dec_valid_nxt;
      dec_word_r     <= dec_word_nxt;
    end
  end

  assign o_level_status_word = lsw_r;
  assign o_result            = result_r;
  assign o_result_we         = result_we_r;
  assign o_branch_done       = branch_done_r;
  assign o_branch_taken      = branch_taken_r;
  assign o_program_check     = prog_check_r;
  assign o_trace_irq         = trace_irq_r;
  assign o_dec_valid         = dec_valid_r;

  // the function field position varies by group; bits 11-15 suit the
  // register-register group, other groups reinterpret it downstream
  assign o_dec_opcode = dec_word_r[status_pkg::OPC_MSB:status_pkg::OPC_LSB];
  assign o_dec_func   = dec_word_r[status_pkg::FUNC_MSB:status_pkg::FUNC_LSB];
  assign o_dec_reg    = dec_word_r[status_pkg::REG_MSB:status_pkg::REG_LSB];
  assign o_dec_imm    = dec_word_r[status_pkg::IMM_MSB:status_pkg::IMM_LSB];
  assign o_dec_add_byte_imm = dec_valid_r
      & (dec_word_r[status_pkg::OPC_MSB:status_pkg::OPC_LSB]
         == status_pkg::OPC_ADD_BYTE_IMM);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_wrap_add;
    i_clk_en && op_take && !i_branch_valid && i_op == status_pkg::add_word_op
      && i_opnd_a == 16'hFFFF && i_opnd_b == 16'h0001;
  endsequence
  sequence s_carry_add;
    i_clk_en && op_take && i_op == status_pkg::add_word_with_carry_op
      && i_opnd_a == 16'h0000 && i_opnd_b == 16'h0000;
  endsequence
  sequence s_priv_try;
    i_clk_en && (i_set_level_block_op || i_level_exit_op) && !lsw_r[status_pkg::SUP_BIT];
  endsequence

  chk_chain_carry_in: assert property (
    s_wrap_add ##1 (!i_op_valid && !i_set_level_block_op) ##1 s_carry_add
      |=> o_result == 16'h0001 && !lsw_r[status_pkg::IND_ZERO] && lsw_r[status_pkg::IND_EVEN])
    else $error("carry not chained into word-with-carry add");
  chk_carry_reg_wrap: assert property (
    i_clk_en && op_take && i_op == status_pkg::add_carry_to_reg_op && ind_c
      && i_opnd_a == 16'hFFFF |=> o_result == 16'h0000 && lsw_r[status_pkg::IND_CARRY])
    else $error("add carry to register wrong");
  chk_chain_zero: assert property (
    i_clk_en && op_take && chained && !ind_z |=> !lsw_r[status_pkg::IND_ZERO])
    else $error("zero set after nonzero earlier word");
  chk_chain_even: assert property (
    i_clk_en && op_take && chained |=> $stable(lsw_r[status_pkg::IND_EVEN]))
    else $error("even changed by chained word");
  chk_neg_result: assert property (
    i_clk_en && op_take |=> lsw_r[status_pkg::IND_NEG] == o_result[15])
    else $error("negative does not follow result sign");
  chk_not_cond: assert property (
    i_clk_en && i_branch_valid && i_branch_not && i_cond == status_pkg::cond_zero
      |=> o_branch_done && o_branch_taken == !$past(ind_z))
    else $error("not-condition branch wrong");
  chk_logical_less: assert property (
    i_clk_en && i_branch_valid && !i_branch_not && i_cond == status_pkg::branch_logical_less
      |=> o_branch_taken == $past(ind_c))
    else $error("logically less than not equal to carry");
  chk_logical_ge: assert property (
    i_clk_en && i_branch_valid && !i_branch_not
      && i_cond == status_pkg::branch_logical_greater_equal |=> o_branch_taken == !$past(ind_c))
    else $error("logically greater or equal not equal to no carry");
  chk_priv_refused: assert property (
    s_priv_try |=> o_program_check && lsw_r[status_pkg::SUP_BIT]
      ##1 (!o_program_check || !i_clk_en))
    else $error("privileged op in problem state not refused");
  chk_load_sup: assert property (
    i_clk_en && (i_initial_program_load || i_io_irq) |=> lsw_r[status_pkg::SUP_BIT])
    else $error("supervisor not set by entry event");
  chk_exit_clears: assert property (
    i_clk_en && i_level_exit_op && !i_level_enter && lsw_r[status_pkg::SUP_BIT]
      |=> !lsw_r[status_pkg::INPROC_BIT])
    else $error("level exit left in-process bit set");
  chk_trace_raise: assert property (
    i_clk_en && i_instr_start && lsw_r[status_pkg::TRACE_BIT] |=> o_trace_irq)
    else $error("trace interrupt missing");
  chk_mask_blocks: assert property (
    !lsw_r[status_pkg::SMASK_BIT] |-> !o_prio_irq_grant)
    else $error("priority interrupt passed summary mask");
endmodule : status_condition_unit

// >>> verif/status_condition_unit_bench.sv
/*
 * self-checking bench for the status and condition unit: chained arithmetic,
 * compare, branch conditions, state bits and one-word decode.
 * assumes the core package, carrier interface and adder are compiled first.
 */
module status_condition_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   i_clock;
  logic                   i_rst_n;
  logic                   i_clk_en;
  logic                   i_instr_valid;
  logic [0:15]            i_instr;
  logic                   i_op_valid;
  status_pkg::alu_op_type i_op;
  logic [15:0]            i_opnd_a;
  logic [15:0]            i_opnd_b;
  logic                   i_branch_valid;
  logic                   i_branch_not;
  status_pkg::cond_type   i_cond;
  logic [7:0]             ev_m;
  logic [0:15]            i_set_level_block_op_word;
  logic                   i_prio_irq_req;
  logic [0:15]            o_level_status_word;
  logic [15:0]            o_result;
  logic                   o_result_we;
  logic                   o_branch_done;
  logic                   o_branch_taken;
  logic                   o_program_check;
  logic                   o_trace_irq;
  logic                   o_prio_irq_grant;
  logic                   o_dec_valid;
  logic [4:0]             o_dec_opcode;
  logic [4:0]             o_dec_func;
  logic [2:0]             o_dec_reg;
  logic [7:0]             o_dec_imm;
  logic                   o_dec_add_byte_imm;
  int                     bad_count;
  int                     cmp_count;
  int                     cycles;

  status_condition_unit dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_opnd_a(i_opnd_a), .i_opnd_b(i_opnd_b), .i_privileged(ev_m[7]),
    .i_branch_valid(i_branch_valid), .i_branch_not(i_branch_not), .i_cond(i_cond),
    .i_class_irq(ev_m[0]), .i_io_irq(ev_m[1]), .i_initial_program_load(ev_m[2]),
    .i_level_enter(ev_m[3]), .i_level_exit_op(ev_m[4]), .i_set_level_block_op(ev_m[5]),
    .i_set_level_block_op_word(i_set_level_block_op_word), .i_instr_start(ev_m[6]), .i_prio_irq_req(i_prio_irq_req),
    .o_level_status_word(o_level_status_word), .o_result(o_result),
    .o_result_we(o_result_we), .o_branch_done(o_branch_done),
    .o_branch_taken(o_branch_taken), .o_program_check(o_program_check),
    .o_trace_irq(o_trace_irq), .o_prio_irq_grant(o_prio_irq_grant),
    .o_dec_valid(o_dec_valid), .o_dec_opcode(o_dec_opcode), .o_dec_func(o_dec_func),
    .o_dec_reg(o_dec_reg), .o_dec_imm(o_dec_imm), .o_dec_add_byte_imm(o_dec_add_byte_imm)
  );

  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ind packs even, carry, overflow, negative, zero from msb to lsb
  task automatic op(input status_pkg::alu_op_type k, input logic [15:0] a,
                    input logic [15:0] b, input logic [15:0] res, input logic [4:0] ind);
    @(posedge i_clock);
    i_op_valid <= 1'h1;
    i_op       <= k;
    i_opnd_a   <= a;
    i_opnd_b   <= b;
    @(posedge i_clock);
    i_op_valid <= 1'h0;
    #1;
    chk(o_result, res);
    chk(o_result_we, (k != status_pkg::compare_op));
    chk(o_level_status_word, {ind, 11'h080});
  endtask : op

  function automatic logic cond_exp(input int c, input logic [4:0] ind);
    logic e, cy, v, n, z;
    {e, cy, v, n, z} = ind;
    case (c)
      0: return z;
      1: return !z;
      2: return !n && !z;
      3: return n || z;
      4: return n;
      5: return !n;
      6: return e;
      7: return !e;
      8: return n ^ v;
      9: return (n ^ v) || z;
      10: return !(n ^ v);
      11: return !(n ^ v) && !z;
      12: return cy || z;
      13: return cy;
      14: return !cy && !z;
      default: return !cy;
    endcase
  endfunction : cond_exp

  task automatic branch_all(input logic [4:0] ind);
    for (int c = 0; c < 32; c++) begin
      @(posedge i_clock);
      i_branch_valid <= 1'h1;
      i_cond         <= status_pkg::cond_type'(c[3:0]);
      i_branch_not   <= c[4];
      @(posedge i_clock);
      i_branch_valid <= 1'h0;
      #1;
      chk(o_branch_done, 32'h1);
      chk(o_branch_taken, cond_exp(c % 16, ind) ^ c[4]);
    end
  endtask : branch_all

  // m: class, io, load, enter, exit, set-level-block, start, privileged
  task automatic ev(input logic [7:0] m, input logic [0:15] w, input logic en,
                    input logic [15:0] lsw, input logic [1:0] pt);
    @(posedge i_clock);
    ev_m        <= m;
    i_set_level_block_op_word <= w;
    i_clk_en    <= en;
    @(posedge i_clock);
    ev_m     <= 8'h00;
    i_clk_en <= 1'h1;
    #1;
    chk(o_level_status_word, lsw);
    chk({o_program_check, o_trace_irq}, pt);
  endtask : ev

  task automatic dec(input logic [0:15] w, input logic [22:0] exp);
    @(posedge i_clock);
    i_instr_valid <= 1'h1;
    i_instr       <= w;
    @(posedge i_clock);
    i_instr_valid <= 1'h0;
    #1;
    chk({o_dec_valid, o_dec_opcode, o_dec_func, o_dec_reg, o_dec_imm, o_dec_add_byte_imm},
        exp);
  endtask : dec

  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    {i_rst_n, i_instr_valid, i_op_valid, i_branch_valid, i_branch_not} = 5'h00;
    {i_instr, i_opnd_a, i_opnd_b, i_set_level_block_op_word} = 64'h0;
    {ev_m, i_clk_en, i_prio_irq_req} = 10'h002;
    i_op = status_pkg::add_word_op;
    i_cond = status_pkg::cond_zero;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'h1;
    #1;
    chk(o_level_status_word, 16'h0080);
    chk(o_result, 16'h0000);
    op(status_pkg::add_word_op, 16'hFFFF, 16'h0001, 16'h0000, 5'h19);
    op(status_pkg::add_word_with_carry_op, 16'h0000, 16'h0000, 16'h0001, 5'h10);
    op(status_pkg::add_word_with_carry_op, 16'h7FFF, 16'h0001, 16'h8000, 5'h16);
    op(status_pkg::add_word_op, 16'hFFFF, 16'h0002, 16'h0001, 5'h08);
    op(status_pkg::add_carry_to_reg_op, 16'hFFFF, 16'h0000, 16'h0000, 5'h08);
    op(status_pkg::sub_word_op, 16'h0000, 16'h0001, 16'hFFFF, 5'h0A);
    op(status_pkg::sub_carry_from_reg_op, 16'h0000, 16'h0000, 16'hFFFF, 5'h0A);
    op(status_pkg::sub_word_with_carry_op, 16'h0001, 16'h0000, 16'h0000, 5'h00);
    op(status_pkg::sub_word_op, 16'h0005, 16'h0005, 16'h0000, 5'h11);
    op(status_pkg::sub_word_with_carry_op, 16'h0003, 16'h0003, 16'h0000, 5'h11);
    op(status_pkg::add_byte_immediate_op, 16'h0010, 16'h00FF, 16'h000F, 5'h08);
    op(status_pkg::compare_op, 16'h0002, 16'h0007, 16'hFFFB, 5'h0A);
    branch_all(5'h0A);
    op(status_pkg::compare_op, 16'h0007, 16'h0002, 16'h0005, 5'h00);
    branch_all(5'h00);
    op(status_pkg::compare_op, 16'h0003, 16'h0003, 16'h0000, 5'h11);
    branch_all(5'h11);
    op(status_pkg::compare_op, 16'h8000, 16'h0001, 16'h7FFF, 5'h04);
    branch_all(5'h04);
    dec(16'h05A5, {1'h1, 5'h00, 5'h05, 3'h5, 8'hA5, 1'h1});
    dec(16'h7125, {1'h1, 5'h0E, 5'h05, 3'h1, 8'h25, 1'h0});
    @(posedge i_clock);
    i_prio_irq_req <= 1'h1;
    ev(8'h20, 16'hFFFF, 1'h1, 16'hF8F0, 2'h0);
    chk(o_prio_irq_grant, 32'h1);
    ev(8'h20, 16'h0000, 1'h1, 16'h0000, 2'h0);
    chk(o_prio_irq_grant, 32'h0);
    // privileged attempts in problem state are refused and trap
    ev(8'h20, 16'hFFFF, 1'h1, 16'h0080, 2'h2);
    ev(8'h80, 16'h0000, 1'h1, 16'h0080, 2'h0);
    ev(8'h20, 16'h0000, 1'h1, 16'h0000, 2'h0);
    ev(8'h80, 16'h0000, 1'h1, 16'h0080, 2'h2);
    ev(8'h20, 16'h0000, 1'h1, 16'h0000, 2'h0);
    ev(8'h10, 16'h0000, 1'h1, 16'h0080, 2'h2);
    ev(8'h08, 16'h0000, 1'h1, 16'h00C0, 2'h0);
    ev(8'h10, 16'h0000, 1'h1, 16'h0080, 2'h0);
    ev(8'h20, 16'h0020, 1'h1, 16'h0020, 2'h0);
    ev(8'h40, 16'h0000, 1'h1, 16'h00A0, 2'h1);
    ev(8'h40, 16'h0000, 1'h1, 16'h00A0, 2'h1);
    ev(8'h20, 16'h0000, 1'h1, 16'h0000, 2'h0);
    ev(8'h40, 16'h0000, 1'h1, 16'h0000, 2'h0);
    for (int i = 0; i < 3; i++) begin
      ev(8'h00, 16'h0000, 1'h1, 16'h0000, 2'h0);
      ev(8'h01 << i, 16'h0000, 1'h1, 16'h0080, 2'h0);
      ev(8'h20, 16'h0000, 1'h1, 16'h0000, 2'h0);
    end
    // a disabled clock must freeze the status word
    ev(8'h01, 16'h0000, 1'h0, 16'h0000, 2'h0);
    stop_test();
  end
endmodule : status_condition_unit_bench
